//--- design/rsldo_consts.vh
`ifndef RSLDO_CONSTS_VH
`define RSLDO_CONSTS_VH

// register indices; byte address is four times the index
`define RS_IDX_BUCK        8'h38
`define RS_IDX_LDO1        8'h39
`define RS_IDX_LDO2        8'h3a
`define RS_IDX_STAT        8'h3b

// buck function register layout and regulator code width and ceiling
`define RS_SPREAD_EN_BIT   0
`define RS_SPREAD_RATE_BIT 1
`define RS_BUCK_RESET      8'h0a
`define RS_BUCK_FIXED      6'h02
`define RS_CODE_W          5
`define RS_CODE_MAX        5'h19

// status register layout
`define RS_STAT_LOCK_BIT   0
`define RS_STAT_SPREAD_BIT 1

// axi responses
`define RS_RESP_OKAY       2'h0
`define RS_RESP_SLVERR     2'h2

// timing
`define RS_CLK_HZ          100000000
`define RS_SW_HZ           2000000
`define RS_SW_PERIOD_CYC   (`RS_CLK_HZ / `RS_SW_HZ)
`define RS_SYNC_KHZ        13000
`define RS_SW_KHZ          2000
`define RS_MOD_FAST_HZ     10000
`define RS_MOD_SLOW_HZ     2000
`define RS_SPREAD_DEV_CYC  5
`define RS_STEP_FAST       ((`RS_SW_HZ / `RS_MOD_FAST_HZ) / (4 * `RS_SPREAD_DEV_CYC))
`define RS_STEP_SLOW       ((`RS_SW_HZ / `RS_MOD_SLOW_HZ) / (4 * `RS_SPREAD_DEV_CYC))
`define RS_SYNC_LOSS_CYC   32

`endif

//--- design/rsldo_buck_clk.v
`include "rsldo_consts.vh"

module rsldo_buck_clk (
    // clock and reset
    input  wire clk,
    input  wire nrst,
    // external sync pin
    input  wire sync_in,
    // control from registers
    input  wire spread_enable,
    input  wire spread_rate_select,
    // switching enable and status
    output reg  sw_tick,
    output reg  sync_locked,
    output reg  spread_active
);

    // integer forms of the timing constants, cut to the counter widths below
    localparam integer DEV_I    = `RS_SPREAD_DEV_CYC;
    localparam integer DEV2_I   = 2 * `RS_SPREAD_DEV_CYC;
    localparam integer PMIN_I   = `RS_SW_PERIOD_CYC - `RS_SPREAD_DEV_CYC - 1;
    localparam integer STEP_F_I = `RS_STEP_FAST;
    localparam integer STEP_S_I = `RS_STEP_SLOW;
    localparam integer LOSS_I   = `RS_SYNC_LOSS_CYC - 1;
    localparam integer SW_K_I   = `RS_SW_KHZ;
    localparam integer SYNC_K_I = `RS_SYNC_KHZ;

    localparam [7:0]  DEV     = DEV_I[7:0];
    localparam [7:0]  DEV2    = DEV2_I[7:0];
    localparam [7:0]  PMIN_M1 = PMIN_I[7:0];
    localparam [7:0]  STEP_F  = STEP_F_I[7:0];
    localparam [7:0]  STEP_S  = STEP_S_I[7:0];
    localparam [7:0]  LOSS_M1 = LOSS_I[7:0];
    localparam [13:0] SW_K    = SW_K_I[13:0];
    localparam [13:0] SYNC_K  = SYNC_K_I[13:0];

    reg  [7:0]  cnt_reg;
    reg  [7:0]  pos_reg;
    reg         dir_reg;
    reg  [7:0]  step_reg;
    reg         sync_d_reg;
    reg         sync_q_reg;
    reg  [7:0]  loss_reg;
    reg  [13:0] acc_reg;
    wire [7:0]  step_end;
    wire        int_tick;
    wire        sync_rise;
    wire [13:0] acc_sum;
    wire        acc_wrap;

    // period of internal clock is pmin + pos, centred on the 2 mhz period
    assign int_tick  = (cnt_reg == PMIN_M1 + pos_reg);
    assign step_end  = spread_rate_select ? (STEP_S - 8'h01) : (STEP_F - 8'h01);
    assign sync_rise = sync_d_reg & ~sync_q_reg;
    assign acc_sum   = acc_reg + SW_K;
    assign acc_wrap  = (acc_sum >= SYNC_K);

    // internal oscillator divider
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_reg <= 8'h00;
        else if (int_tick)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= cnt_reg + 8'h01;
    end

    // triangular sweep of the period, moved only at period ends
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pos_reg  <= DEV;
            dir_reg  <= 1'b0;
            step_reg <= 8'h00;
        end
        else if (int_tick)
        begin
            if (!spread_active)
            begin
                pos_reg  <= DEV;  // disabled: fixed centre period
                dir_reg  <= 1'b0;
                step_reg <= 8'h00;
            end
            else if (step_reg == step_end)
            begin
                step_reg <= 8'h00;
                if (!dir_reg)
                begin
                    if (pos_reg == DEV2)
                    begin
                        dir_reg <= 1'b1;
                        pos_reg <= pos_reg - 8'h01;
                    end
                    else
                        pos_reg <= pos_reg + 8'h01;
                end
                else
                begin
                    if (pos_reg == 8'h00)
                    begin
                        dir_reg <= 1'b0;
                        pos_reg <= pos_reg + 8'h01;
                    end
                    else
                        pos_reg <= pos_reg - 8'h01;
                end
            end
            else
                step_reg <= step_reg + 8'h01;
        end
    end

    // sync pin edge detect; a pin tied low never produces an edge
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_d_reg <= 1'b0;
            sync_q_reg <= 1'b0;
        end
        else
        begin
            sync_d_reg <= sync_in;
            sync_q_reg <= sync_d_reg;
        end
    end

    // lock on edges, drop back to internal after a silent window
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            loss_reg    <= 8'h00;
            sync_locked <= 1'b0;
        end
        else if (sync_rise)
        begin
            loss_reg    <= 8'h00;
            sync_locked <= 1'b1;
        end
        else if (loss_reg == LOSS_M1)
            sync_locked <= 1'b0;
        else
            loss_reg <= loss_reg + 8'h01;
    end

    // fractional 2/13 divider: two ticks per thirteen sync edges
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            acc_reg <= 14'h0000;
        else if (sync_rise)
            acc_reg <= acc_wrap ? (acc_sum - SYNC_K) : acc_sum;
    end

    // tick source select; spreading only on the internal clock
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sw_tick       <= 1'b0;
            spread_active <= 1'b0;
        end
        else
        begin
            sw_tick       <= sync_locked ? (sync_rise & acc_wrap) : int_tick;
            spread_active <= spread_enable & ~sync_locked;
        end
    end

endmodule

//--- design/rsldo_ctrl.v
`include "rsldo_consts.vh"

module rsldo_ctrl #(
    parameter                  AW           = 12,
    parameter [`RS_CODE_W-1:0] LDO1_DEFAULT = 5'h17,
    parameter [`RS_CODE_W-1:0] LDO2_DEFAULT = 5'h08
) (
    // clock and reset
    input  wire                  clk,
    input  wire                  nrst,
    // axi4-lite write address
    input  wire [AW-1:0]         s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output wire                  s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output wire                  s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    // axi4-lite read address
    input  wire [AW-1:0]         s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output wire                  s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    // sync pin
    input  wire                  sync_in,
    // regulator controls
    output wire [`RS_CODE_W-1:0] ldo1_code,
    output wire [`RS_CODE_W-1:0] ldo2_code,
    output wire                  buck_sw_tick,
    output wire                  sync_locked,
    output wire                  spread_active
);

    reg                  aw_held_reg;
    reg                  w_held_reg;
    reg  [AW-1:0]        awaddr_reg;
    reg  [31:0]          wdata_reg;
    reg                  wstrb0_reg;
    reg                  spread_enable_reg;
    reg                  spread_rate_reg;
    reg  [`RS_CODE_W-1:0] ldo1_reg;
    reg  [`RS_CODE_W-1:0] ldo2_reg;
    reg  [31:0]          rd_data_next;
    reg                  rd_hit_next;
    wire                 wr_fire;
    wire                 wr_hit;
    wire                 wr_en;

    // reset pattern of the buck function register, kept at full width
    // so each field can be bit-selected as a constant
    localparam [7:0] BUCK_RST = `RS_BUCK_RESET;

    // word-aligned decode; address bits above the index must be zero
    function sel_match;
        input [AW-1:0] addr;
        input [7:0]    idx;
        begin
            sel_match = (addr[AW-1:2] == {{(AW-10){1'b0}}, idx});
        end
    endfunction

    // codes above the table top all mean the highest voltage, so store them saturated
    // decoded once here and used by both regulator registers
    function [`RS_CODE_W-1:0] sat_code;
        input [`RS_CODE_W-1:0] code;
        begin
            sat_code = (code > `RS_CODE_MAX) ? `RS_CODE_MAX : code;
        end
    endfunction

    // write channels accepted independently, blocked while a response waits
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    assign wr_fire       = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wr_hit        = sel_match(awaddr_reg, `RS_IDX_BUCK) | sel_match(awaddr_reg, `RS_IDX_LDO1)
                         | sel_match(awaddr_reg, `RS_IDX_LDO2) | sel_match(awaddr_reg, `RS_IDX_STAT);
    // only byte lane 0 carries register data
    assign wr_en         = wr_fire & wstrb0_reg;

    // capture address and data, then answer once both are in
    // a second write waits until the host has taken the response
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= {AW{1'b0}};
            wdata_reg    <= 32'h00000000;
            wstrb0_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RS_RESP_OKAY : `RS_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // control registers; reserved bits are not stored at all
    // a write with byte lane 0 off leaves every field as it was
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            spread_enable_reg <= BUCK_RST[`RS_SPREAD_EN_BIT];
            spread_rate_reg   <= BUCK_RST[`RS_SPREAD_RATE_BIT];
            ldo1_reg          <= LDO1_DEFAULT;
            ldo2_reg          <= LDO2_DEFAULT;
        end
        else if (wr_en)
        begin
            if (sel_match(awaddr_reg, `RS_IDX_BUCK))
            begin
                spread_enable_reg <= wdata_reg[`RS_SPREAD_EN_BIT];
                spread_rate_reg   <= wdata_reg[`RS_SPREAD_RATE_BIT];
            end
            if (sel_match(awaddr_reg, `RS_IDX_LDO1))
                ldo1_reg <= sat_code(wdata_reg[`RS_CODE_W-1:0]);
            if (sel_match(awaddr_reg, `RS_IDX_LDO2))
                ldo2_reg <= sat_code(wdata_reg[`RS_CODE_W-1:0]);
        end
    end

    // stored codes are already saturated, so pins and readback always agree
    assign ldo1_code = ldo1_reg;
    assign ldo2_code = ldo2_reg;

    // read mux; reserved bits read zero except the fixed buck pattern
    // unmapped reads return zero with an error response
    always @*
    begin
        rd_data_next = 32'h00000000;
        rd_hit_next  = 1'b1;
        if (sel_match(s_axi_araddr, `RS_IDX_BUCK))
            rd_data_next[7:0] = {`RS_BUCK_FIXED, spread_rate_reg, spread_enable_reg};
        else if (sel_match(s_axi_araddr, `RS_IDX_LDO1))
            rd_data_next[`RS_CODE_W-1:0] = ldo1_code;
        else if (sel_match(s_axi_araddr, `RS_IDX_LDO2))
            rd_data_next[`RS_CODE_W-1:0] = ldo2_code;
        else if (sel_match(s_axi_araddr, `RS_IDX_STAT))
        begin
            rd_data_next[`RS_STAT_LOCK_BIT]   = sync_locked;
            rd_data_next[`RS_STAT_SPREAD_BIT] = spread_active;
        end
        else
            rd_hit_next = 1'b0;
    end

    // one read at a time; the address is taken only while no data waits
    assign s_axi_arready = ~s_axi_rvalid;

    // registered answer; data and response stand until rready
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data_next;
            s_axi_rresp  <= rd_hit_next ? `RS_RESP_OKAY : `RS_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // buck switching clock: internal with optional spread, or sync-locked
    rsldo_buck_clk u_buck_clk (
        .clk                (clk),
        .nrst               (nrst),
        .sync_in            (sync_in),
        .spread_enable      (spread_enable_reg),
        .spread_rate_select (spread_rate_reg),
        .sw_tick            (buck_sw_tick),
        .sync_locked        (sync_locked),
        .spread_active      (spread_active)
    );

endmodule

//--- test/rsldo_ctrl_monitor.sv
module rsldo_ctrl_monitor (
    // clock and reset
    input logic        clk,
    input logic        nrst,
    // bus handshakes
    input logic        s_axi_awready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // regulator side
    input logic        sync_in,
    input logic [4:0]  ldo1_code,
    input logic [4:0]  ldo2_code,
    input logic        buck_sw_tick,
    input logic        sync_locked,
    input logic        spread_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [6:0] gap_reg;
    logic [7:0] unl_reg;
    // gap since last tick, and unlocked streak so a gap is judged only in internal mode
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_reg <= 7'h00;
            unl_reg <= 8'h00;
        end
        else
        begin
            gap_reg <= buck_sw_tick ? 7'h01 : gap_reg + {6'h00, gap_reg != 7'h7f};
            unl_reg <= sync_locked ? 8'h00 : unl_reg + {7'h00, unl_reg != 8'hff};
        end
    end
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken during response");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during response");
    ldo1_sat_a: assert property (ldo1_code <= 5'h19) else $error("first code above ceiling");
    ldo2_sat_a: assert property (ldo2_code <= 5'h19) else $error("second code above ceiling");
    spread_gate_a: assert property (spread_active |-> !$past(sync_locked)) else $error("spread while locked");
    int_gap_a: assert property (buck_sw_tick && unl_reg >= 8'h78 |-> gap_reg >= 7'h2d && gap_reg <= 7'h37)
        else $error("internal period out of range");
    lock_rise_a: assert property ($rose(sync_in) |-> ##[1:4] sync_locked) else $error("sync not locked");
    cover property (buck_sw_tick && spread_active);
    cover property ($rose(sync_locked));
    cover property (buck_sw_tick && sync_locked);
endmodule
bind rsldo_ctrl rsldo_ctrl_monitor i_mon (.clk(clk), .nrst(nrst), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .sync_in(sync_in),
    .ldo1_code(ldo1_code), .ldo2_code(ldo2_code), .buck_sw_tick(buck_sw_tick), .sync_locked(sync_locked),
    .spread_active(spread_active));

//--- test/rsldo_sync_src.sv
module rsldo_sync_src (
    // clock, control and pin
    input  logic clk,
    input  logic run,
    output logic sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int phase = 0;
    // 13 mhz system clock: 26 half periods per 100 bench cycles, changed on clock edges
    // so the pin behaves as a synchronous input; held at ground when unused
    always @(posedge clk)
    begin
        phase <= (phase + 26) % 100;
        sync_out <= !run ? 1'h0 : ((phase + 26 >= 100) ? ~sync_out : sync_out);
    end
endmodule

//--- test/rsldo_ctrl_tb_top.sv
module rsldo_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0;
    logic        nrst = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awv = 1'h0, wv = 1'h0, br = 1'h1, arv = 1'h0, rr = 1'h1, sync_run = 1'h0;
    wire         awrdy, wrdy, bv, arrdy, rv, sync_in, tick, locked, spr;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [4:0]  ldo1, ldo2;
    logic [1:0]  resp;
    logic [31:0] rd, ex;
    logic [7:0]  codes [4] = '{8'h00, 8'h19, 8'h1a, 8'hff};
    int          miscompares = 0, comparisons = 0, lo, hi, nt, g;
    always #5 clk = ~clk;
    rsldo_ctrl i_rsldo_ctrl (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .sync_in(sync_in), .ldo1_code(ldo1), .ldo2_code(ldo2), .buck_sw_tick(tick), .sync_locked(locked),
        .spread_active(spr));
    rsldo_sync_src i_rsldo_sync_src (.clk(clk), .run(sync_run), .sync_out(sync_in));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // response readies stay high, so each answer is taken at the edge where it is first seen
    task wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= d;
        wstrb <= s;
        awv <= 1'h1;
        wv <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awv && awrdy) awv <= 1'h0;
            if (wv && wrdy) wv <= 1'h0;
        end while (!bv);
        resp = bresp;
    endtask
    task rdr(input logic [7:0] idx);
        araddr <= {2'h0, idx, 2'h0};
        arv <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arv && arrdy) arv <= 1'h0;
        end while (!rv);
        rd = rdata;
        resp = rresp;
    endtask
    // shortest and longest switching gap and tick count over n cycles
    task meas(input int n);
        lo = 999;
        hi = 0;
        nt = 0;
        g = 0;
        repeat (n)
        begin
            @(posedge clk);
            g++;
            if (tick)
            begin
                if (nt > 0 && g < lo) lo = g;
                if (nt > 0 && g > hi) hi = g;
                nt++;
                g = 0;
            end
        end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        chk(32'(ldo1), 32'h17);
        chk(32'(ldo2), 32'h08);
        nrst <= 1'h1;
        rdr(8'h38);
        chk(rd, 32'h0a);
        rdr(8'h39);
        chk(rd, 32'h17);
        chk(32'(ldo2), 32'h08);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h38, 32'hfc | i, 4'h1);
            rdr(8'h38);
            chk(rd, 32'h08 | i);
        end
        for (int i = 0; i < 8; i++)
        begin
            ex = (codes[i/2] & 8'h1f) > 8'h19 ? 32'h19 : 32'(codes[i/2] & 8'h1f);
            wr(8'h39 + 8'(i % 2), {24'hffffff, codes[i/2]}, 4'h1);
            rdr(8'h39 + 8'(i % 2));
            chk(rd, ex);
            chk(32'((i % 2) ? ldo2 : ldo1), ex);
        end
        wr(8'h39, 32'h05, 4'h0);
        rdr(8'h39);
        chk(rd, 32'h19);
        wr(8'h3f, 32'h01, 4'h1);
        chk(32'(resp), 32'h2);
        rdr(8'h3f);
        chk(rd, 32'h0);
        chk(32'(resp), 32'h2);
        wr(8'h38, 32'h02, 4'h1);
        // let one period end so the centre period is back before measuring
        repeat (60) @(posedge clk);
        meas(2000);
        chk({lo[7:0], hi[7:0]}, 16'h3232);
        wr(8'h38, 32'h01, 4'h1);
        meas(12000);
        chk({lo[7:0], hi[7:0]}, 16'h2d37);
        rdr(8'h3b);
        chk(rd, 32'h02);
        wr(8'h38, 32'h03, 4'h1);
        meas(12000);
        chk(32'(hi - lo <= 6), 32'h1);
        sync_run <= 1'h1;
        repeat (50) @(posedge clk);
        rdr(8'h3b);
        chk(rd, 32'h01);
        chk(32'({spr, locked}), 32'h1);
        meas(10000);
        chk(32'(nt >= 199 && nt <= 201), 32'h1);
        sync_run <= 1'h0;
        repeat (60) @(posedge clk);
        rdr(8'h3b);
        chk(rd, 32'h02);
        close_out();
    end
    // whole run is about 36300 cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule
